// ===== rtl/asp_axil_slv.sv
`timescale 1ns/10ps
`include "asp_cfg.svh"
module asp_axil_slv
  import asp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,      // System clock
  input  wire logic              aresetn,   // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] s_awaddr,  // Write address
  input  wire logic              s_awvalid, // Write address valid
  output logic                   s_awready, // Write address ready
  input  wire logic [31:0]       s_wdata,   // Write data
  input  wire logic [3:0]        s_wstrb,   // Write strobes
  input  wire logic              s_wvalid,  // Write data valid
  output logic                   s_wready,  // Write data ready
  output logic [1:0]             s_bresp,   // Write response
  output logic                   s_bvalid,  // Write response valid
  input  wire logic              s_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_araddr,  // Read address
  input  wire logic              s_arvalid, // Read address valid
  output logic                   s_arready, // Read address ready
  output logic [31:0]            s_rdata,   // Read data
  output logic [1:0]             s_rresp,   // Read response
  output logic                   s_rvalid,  // Read data valid
  input  wire logic              s_rready,  // Read data ready
  output logic                   wr_en,     // Register write pulse
  output logic [ADDR_W-1:0]      wr_addr,   // Register write address
  output logic [31:0]            wr_data,   // Register write data
  output logic [3:0]             wr_strb,   // Register write strobes
  input  wire logic              wr_hit,    // Write address mapped
  output logic [ADDR_W-1:0]      rd_addr,   // Register read address
  input  wire logic [31:0]       rd_data,   // Register read data
  input  wire logic              rd_hit     // Read address mapped
);

  logic              aw_hold_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_hold_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_now;
  logic              w_now;

  // Address and data are taken in either order
  assign s_awready = !aw_hold_q && !s_bvalid;
  assign s_wready  = !w_hold_q && !s_bvalid;
  assign aw_now    = aw_hold_q || (s_awvalid && s_awready);
  assign w_now     = w_hold_q || (s_wvalid && s_wready);
  assign wr_en     = aw_now && w_now;
  assign wr_addr   = aw_hold_q ? aw_addr_q : s_awaddr;
  assign wr_data   = w_hold_q ? w_data_q : s_wdata;
  assign wr_strb   = w_hold_q ? w_strb_q : s_wstrb;

  // Holding stage for a lone address or data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_hold_q <= aw_now && !wr_en;
      w_hold_q  <= w_now && !wr_en;
      if (s_awvalid && s_awready) aw_addr_q <= s_awaddr;
      if (s_wvalid && s_wready) begin
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= `ASP_RESP_OKAY;
    end else if (wr_en) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Read channel, data registered one cycle after the address
  assign s_arready = !s_rvalid;
  assign rd_addr   = s_araddr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= `ASP_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_hit ? rd_data : 32'h0000_0000;
      s_rresp  <= rd_hit ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule : asp_axil_slv

// ===== rtl/asp_cfg.svh
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// Register byte offsets
`define ASP_OFS_DIR      8'h00
`define ASP_OFS_LATCH    8'h04
`define ASP_OFS_CONFIG   8'h08
`define ASP_OFS_CHSEL    8'h0C
`define ASP_OFS_AMPCTL   8'h10
`define ASP_OFS_PINS     8'h14
`define ASP_OFS_STATUS   8'h18
`define ASP_OFS_ROLES    8'h1C

// Reset values
`define ASP_RST_DIR      8'hFF
`define ASP_RST_LATCH    8'h00
`define ASP_RST_CONFIG   8'hFF
`define ASP_RST_CHSEL    4'hF
`define ASP_RST_AMP      2'h0

// Field positions
`define ASP_BIT_OPA_EN   7
`define ASP_BIT_PGA_EN   6
`define ASP_BIT_PGA_ACT  8

// Channel selector codes
`define ASP_CH_PGA       4'h8

// AXI responses
`define ASP_RESP_OKAY    2'h0
`define ASP_RESP_SLVERR  2'h2

`endif

// ===== rtl/asp_pin_role.sv
`timescale 1ns/10ps
module asp_pin_role
  import asp_pkg::*;
#(
  parameter asp_kind_e KIND = KIND_PLAIN
) (
  input  wire logic  analog,  // Pin in analog use
  input  wire logic  dir_in,  // Direction bit, 1 is input
  input  wire logic  opa_en,  // Op-amp enable
  input  wire logic  pga_en,  // Gain-amp enable
  input  wire logic  ch_sel,  // Selector names this pin
  output asp_role_e  role,    // Decoded role
  output logic       conv     // Pin is converted
);

  // Role decode for one pin
  always_comb begin
    role = ROLE_BAD;
    conv = 1'b0;
    if (!analog) begin
      if (ch_sel) begin
        role = ROLE_BAD;
      end else if (KIND == KIND_OPA_OUT && opa_en) begin
        role = ROLE_BAD;
      end else begin
        role = dir_in ? ROLE_DIG_IN : ROLE_DIG_OUT;
      end
    end else if (!dir_in) begin
      role = ROLE_BAD;
    end else begin
      case (KIND)
        KIND_OPA_IN: begin
          if (!opa_en) begin
            role = ROLE_ANA_IN;
            conv = ch_sel;
          end else begin
            role = ch_sel ? ROLE_BAD : ROLE_OPA_IN;
          end
        end
        KIND_OPA_OUT: begin
          case ({opa_en, pga_en})
            2'b00:   role = ROLE_ANA_IN;
            2'b01:   role = ROLE_PGA_IN;
            2'b10:   role = ROLE_OPA_OUT;
            default: role = ROLE_OPA_OUT_PGA_IN;
          endcase
          conv = ch_sel;
        end
        default: begin
          role = ROLE_ANA_IN;
          conv = ch_sel;
        end
      endcase
    end
  end

endmodule : asp_pin_role

// ===== rtl/asp_pkg.sv
package asp_pkg;

  // Role of one shared pin
  typedef enum logic [2:0] {
    ROLE_DIG_IN,
    ROLE_DIG_OUT,
    ROLE_ANA_IN,
    ROLE_OPA_IN,
    ROLE_PGA_IN,
    ROLE_OPA_OUT,
    ROLE_OPA_OUT_PGA_IN,
    ROLE_BAD
  } asp_role_e;

  // Analog sharing class of a pin
  typedef enum logic [1:0] {
    KIND_OPA_IN,
    KIND_OPA_OUT,
    KIND_PLAIN
  } asp_kind_e;

endpackage : asp_pkg

// ===== rtl/asp_port.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "asp_cfg.svh"
module asp_port
  import asp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NPINS  = 8
) (
  input  wire logic              aclk,          // System clock
  input  wire logic              aresetn,       // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] s_awaddr,      // Write address
  input  wire logic              s_awvalid,     // Write address valid
  output logic                   s_awready,     // Write address ready
  input  wire logic [31:0]       s_wdata,       // Write data
  input  wire logic [3:0]        s_wstrb,       // Write strobes
  input  wire logic              s_wvalid,      // Write data valid
  output logic                   s_wready,      // Write data ready
  output logic [1:0]             s_bresp,       // Write response
  output logic                   s_bvalid,      // Write response valid
  input  wire logic              s_bready,      // Write response ready
  input  wire logic [ADDR_W-1:0] s_araddr,      // Read address
  input  wire logic              s_arvalid,     // Read address valid
  output logic                   s_arready,     // Read address ready
  output logic [31:0]            s_rdata,       // Read data
  output logic [1:0]             s_rresp,       // Read response
  output logic                   s_rvalid,      // Read data valid
  input  wire logic              s_rready,      // Read data ready
  input  wire logic [NPINS-1:0]  pin_in,        // Pin levels
  output logic [NPINS-1:0]       pin_out,       // Pin output levels
  output logic [NPINS-1:0]       pin_oe,        // Pin drive enables
  output logic [NPINS-1:0]       dig_in_en,     // Digital input buffers on
  output logic [NPINS-1:0]       ana_conn,      // Pin joined to analog path
  output logic [NPINS-1:0]       conv_pin_sel,  // Pin routed to converter
  output logic                   conv_pga_sel,  // Gain output to converter
  output logic                   opamp_zero_enable, // Op-amp on
  output logic                   gain_amp_enable,   // Gain amp on
  output logic [1:0]             opa_in_conn,   // Pins 0 and 2 feed op-amp
  output logic                   opamp_zero_output_pin, // Op-amp drives pin 1
  output logic                   gain_amp_input_pin,    // Pin 1 feeds gain amp
  output logic                   prohibited     // Some pin set illegally
);

  localparam int PGA_PIN = 1;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              wr_lane0;

  logic [NPINS-1:0] port_direction_reg_q;
  logic [NPINS-1:0] port_output_latch_reg_q;
  logic [NPINS-1:0] analog_digital_pin_config_q;
  logic [3:0]       conversion_channel_select_q;
  logic [1:0]       opamp_zero_control_q;
  logic [NPINS-1:0] pin_smp_q;
  logic             opa_en;
  logic             pga_en;
  logic             pga_sel;

  asp_role_e        role [NPINS];
  logic [NPINS-1:0] conv;
  logic [NPINS-1:0] ch_sel;
  logic [NPINS-1:0] bad;
  logic [NPINS-1:0] is_out;
  logic [NPINS-1:0] is_dig;
  logic [NPINS-1:0] is_ana;
  logic [3*NPINS-1:0] role_bits;
  logic             pga_act;

  // Address decode shared by both bus directions
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic wr);
    logic rw;
    logic ro;
    rw = (a == `ASP_OFS_DIR) || (a == `ASP_OFS_LATCH) || (a == `ASP_OFS_CONFIG) ||
         (a == `ASP_OFS_CHSEL) || (a == `ASP_OFS_AMPCTL);
    ro = (a == `ASP_OFS_PINS) || (a == `ASP_OFS_STATUS) || (a == `ASP_OFS_ROLES);
    return wr ? rw : (rw || ro);
  endfunction : reg_hit

  // Bus slave
  asp_axil_slv #(
    .ADDR_W (ADDR_W)
  ) u_slv (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_hit    (reg_hit(wr_addr, 1'b1)),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_hit    (reg_hit(rd_addr, 1'b0))
  );

  // All writable fields sit in byte lane 0
  assign wr_lane0 = wr_en && wr_strb[0];

  // Direction bits, one per pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_direction_reg_q <= `ASP_RST_DIR;
    end else if (wr_lane0 && wr_addr == `ASP_OFS_DIR) begin
      port_direction_reg_q <= wr_data[NPINS-1:0];
    end
  end

  // Output latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_output_latch_reg_q <= `ASP_RST_LATCH;
    end else if (wr_lane0 && wr_addr == `ASP_OFS_LATCH) begin
      port_output_latch_reg_q <= wr_data[NPINS-1:0];
    end
  end

  // Analog or digital use, 1 is analog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_digital_pin_config_q <= `ASP_RST_CONFIG;
    end else if (wr_lane0 && wr_addr == `ASP_OFS_CONFIG) begin
      analog_digital_pin_config_q <= wr_data[NPINS-1:0];
    end
  end

  // Conversion channel selector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_channel_select_q <= `ASP_RST_CHSEL;
    end else if (wr_lane0 && wr_addr == `ASP_OFS_CHSEL) begin
      conversion_channel_select_q <= wr_data[3:0];
    end
  end

  // Op-amp control, two live bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opamp_zero_control_q <= `ASP_RST_AMP;
    end else if (wr_lane0 && wr_addr == `ASP_OFS_AMPCTL) begin
      opamp_zero_control_q <= {wr_data[`ASP_BIT_OPA_EN], wr_data[`ASP_BIT_PGA_EN]};
    end
  end

  // Pin levels sampled for reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_smp_q <= '0;
    end else begin
      pin_smp_q <= pin_in & is_dig;
    end
  end

  assign opa_en  = opamp_zero_control_q[1];
  assign pga_en  = opamp_zero_control_q[0];
  assign pga_sel = (conversion_channel_select_q == `ASP_CH_PGA);

  // Per-pin role decode
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    localparam asp_kind_e KIND = (i == 0 || i == 2) ? KIND_OPA_IN :
                                 (i == PGA_PIN) ? KIND_OPA_OUT : KIND_PLAIN;
    assign ch_sel[i] = (conversion_channel_select_q == 4'(i));
    asp_pin_role #(
      .KIND (KIND)
    ) u_role (
      .analog (analog_digital_pin_config_q[i]),
      .dir_in (port_direction_reg_q[i]),
      .opa_en (opa_en),
      .pga_en (pga_en),
      .ch_sel (ch_sel[i]),
      .role   (role[i]),
      .conv   (conv[i])
    );
    assign bad[i]    = (role[i] == ROLE_BAD);
    assign is_out[i] = (role[i] == ROLE_DIG_OUT);
    assign is_dig[i] = is_out[i] || (role[i] == ROLE_DIG_IN);
    assign is_ana[i] = !is_dig[i] && !bad[i];
    assign role_bits[3*i +: 3] = role[i];
  end

  // Gain output converted when the selector picks it and pin 1 feeds the gain amp
  assign pga_act = pga_sel && !bad[PGA_PIN] &&
                   (role[PGA_PIN] == ROLE_PGA_IN ||
                    role[PGA_PIN] == ROLE_OPA_OUT_PGA_IN);

  // Register read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `ASP_OFS_DIR:    rd_data[NPINS-1:0] = port_direction_reg_q;
      `ASP_OFS_LATCH:  rd_data[NPINS-1:0] = port_output_latch_reg_q;
      `ASP_OFS_CONFIG: rd_data[NPINS-1:0] = analog_digital_pin_config_q;
      `ASP_OFS_CHSEL:  rd_data[3:0] = conversion_channel_select_q;
      `ASP_OFS_AMPCTL: begin
        rd_data[`ASP_BIT_OPA_EN] = opa_en;
        rd_data[`ASP_BIT_PGA_EN] = pga_en;
      end
      `ASP_OFS_PINS:   rd_data[NPINS-1:0] = pin_smp_q;
      `ASP_OFS_STATUS: begin
        rd_data[NPINS-1:0]       = bad;
        rd_data[`ASP_BIT_PGA_ACT] = pga_act;
      end
      `ASP_OFS_ROLES:  rd_data[3*NPINS-1:0] = role_bits;
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // Digital pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out   <= '0;
      pin_oe    <= '0;
      dig_in_en <= '0;
    end else begin
      pin_out   <= port_output_latch_reg_q & is_out;
      pin_oe    <= is_out;
      dig_in_en <= is_dig;
    end
  end

  // Analog routing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_conn     <= '1;
      conv_pin_sel <= '0;
      conv_pga_sel <= 1'b0;
    end else begin
      ana_conn     <= is_ana;
      conv_pin_sel <= conv & ~bad;
      conv_pga_sel <= pga_act;
    end
  end

  // Amplifier hookup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opamp_zero_enable     <= 1'b0;
      gain_amp_enable       <= 1'b0;
      opa_in_conn           <= 2'h0;
      opamp_zero_output_pin <= 1'b0;
      gain_amp_input_pin    <= 1'b0;
    end else begin
      opamp_zero_enable     <= opa_en;
      gain_amp_enable       <= pga_en;
      opa_in_conn           <= {role[2] == ROLE_OPA_IN, role[0] == ROLE_OPA_IN};
      opamp_zero_output_pin <= (role[PGA_PIN] == ROLE_OPA_OUT) ||
                               (role[PGA_PIN] == ROLE_OPA_OUT_PGA_IN);
      gain_amp_input_pin    <= (role[PGA_PIN] == ROLE_PGA_IN) ||
                               (role[PGA_PIN] == ROLE_OPA_OUT_PGA_IN);
    end
  end

  // Illegal combination flag, software is expected to avoid it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prohibited <= 1'b0;
    end else begin
      prohibited <= |bad;
    end
  end

endmodule : asp_port

// ===== testbench/asp_port_sva.sv
`timescale 1ns/10ps
module asp_port_sva #(
  parameter int NPINS = 8
) (
  input wire logic             aclk,                  // Clock
  input wire logic             aresetn,               // Reset, low
  input wire logic             s_arvalid,             // Read address valid
  input wire logic             s_arready,             // Read address ready
  input wire logic             s_rvalid,              // Read data valid
  input wire logic             s_bvalid,              // Write response valid
  input wire logic             s_bready,              // Write response ready
  input wire logic [1:0]       s_bresp,               // Write response
  input wire logic [NPINS-1:0] pin_out,               // Pin levels out
  input wire logic [NPINS-1:0] pin_oe,                // Pin drive enables
  input wire logic [NPINS-1:0] dig_in_en,             // Digital role
  input wire logic [NPINS-1:0] ana_conn,              // Analog role
  input wire logic [NPINS-1:0] conv_pin_sel,          // Pin to converter
  input wire logic             conv_pga_sel,          // Gain out to converter
  input wire logic             opamp_zero_enable,     // Op-amp on
  input wire logic             gain_amp_enable,       // Gain amp on
  input wire logic [1:0]       opa_in_conn,           // Op-amp inputs
  input wire logic             opamp_zero_output_pin, // Op-amp out on pin 1
  input wire logic             gain_amp_input_pin     // Pin 1 gain input
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pin roles and drives tied to their causes
  property p_drive; (pin_oe & ~dig_in_en) == '0; endproperty
  a_drive: assert property (p_drive) else $error("drive on non digital pin");
  property p_mask; (pin_out & ~pin_oe) == '0; endproperty
  a_mask: assert property (p_mask) else $error("latch leaks to undriven pin");
  property p_rst; $rose(aresetn) |-> ana_conn == '1 && pin_oe == '0; endproperty
  a_rst: assert property (p_rst) else $error("pins not analog after reset");
  property p_excl; (dig_in_en & ana_conn) == '0; endproperty
  a_excl: assert property (p_excl) else $error("pin digital and analog");
  property p_opin; |opa_in_conn |-> opamp_zero_enable; endproperty
  a_opin: assert property (p_opin) else $error("op-amp input while off");
  property p_opout; opamp_zero_output_pin |-> opamp_zero_enable && ana_conn[1]; endproperty
  a_opout: assert property (p_opout) else $error("op-amp output badly set");
  property p_gain_amp_input_pin;
    gain_amp_input_pin |-> gain_amp_enable && ana_conn[1] && !dig_in_en[1];
  endproperty
  a_gain_amp_input_pin: assert property (p_gain_amp_input_pin) else $error("gain input badly set");
  property p_conv; conv_pga_sel |-> gain_amp_enable && conv_pin_sel == '0; endproperty
  a_conv: assert property (p_conv) else $error("gain conversion badly set");
  property p_onehot; $onehot0(conv_pin_sel) && (conv_pin_sel & ~ana_conn) == '0; endproperty
  a_onehot: assert property (p_onehot) else $error("bad pin conversion");

  // Bus handshakes
  property p_bhold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rans; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
endmodule : asp_port_sva

bind asp_port asp_port_sva #(.NPINS(NPINS)) u_sva (
  .aclk, .aresetn, .s_arvalid, .s_arready, .s_rvalid, .s_bvalid, .s_bready, .s_bresp,
  .pin_out, .pin_oe, .dig_in_en, .ana_conn, .conv_pin_sel, .conv_pga_sel,
  .opamp_zero_enable, .gain_amp_enable, .opa_in_conn, .opamp_zero_output_pin,
  .gain_amp_input_pin
);

// ===== testbench/tb_asp_port.sv
`timescale 1ns/10ps
`include "asp_cfg.svh"
module tb_asp_port;
  import asp_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0, pin_in = 0;
  logic [31:0] s_wdata = 0, s_rdata;
  logic [3:0]  s_wstrb = 4'hF;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, opa_in_conn;
  logic [7:0]  pin_out, pin_oe, dig_in_en, ana_conn, conv_pin_sel;
  logic        conv_pga_sel, opamp_zero_enable, gain_amp_enable;
  logic        opamp_zero_output_pin, gain_amp_input_pin, prohibited;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  logic        b_late = 0;

  asp_port u_dut (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_in, .pin_out, .pin_oe, .dig_in_en,
    .ana_conn, .conv_pin_sel, .conv_pga_sel, .opamp_zero_enable, .gain_amp_enable,
    .opa_in_conn, .opamp_zero_output_pin, .gain_amp_input_pin, .prohibited
  );

  // Clock and hang guard
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Write one word; handshake sampled mid-cycle, driven after rising edges
  // With b_late set, bready rises only after bvalid, so the response must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    @(posedge aclk);
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; s_bready <= !b_late;
    hb = 0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_awvalid && s_awready;
      hw = s_wvalid && s_wready;
      hb = s_bvalid && s_bready;
      if (hb) chk("bresp", er, s_bresp);
      @(posedge aclk);
      if (ha) s_awvalid <= 0;
      if (hw) s_wvalid <= 0;
      if (s_bvalid && !s_bready) s_bready <= 1;
    end
    s_bready <= 0;
  endtask : wr

  // Read one word and compare data and response
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, hr;
    @(posedge aclk);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    hr = 0;
    while (!hr) begin
      @(negedge aclk);
      ha = s_arvalid && s_arready;
      hr = s_rvalid;
      if (hr) chk("rdata", e, s_rdata);
      if (hr) chk("rresp", er, s_rresp);
      @(posedge aclk);
      if (ha) s_arvalid <= 0;
    end
    s_rready <= 0;
  endtask : rchk

  // Let pin outputs follow the registers
  task automatic upd();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask : upd

  task automatic t_reset();
    rchk(`ASP_OFS_DIR, 32'hFF, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_LATCH, 32'h00, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_CONFIG, 32'hFF, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_CHSEL, 32'hF, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_AMPCTL, 32'h0, `ASP_RESP_OKAY);
    upd();
    chk("oe", 8'h00, pin_oe);
    chk("ana", 8'hFF, ana_conn);
    chk("dig", 8'h00, dig_in_en);
    $display("test reset done");
  endtask : t_reset

  task automatic t_digital();
    wr(`ASP_OFS_CONFIG, 32'h00, `ASP_RESP_OKAY);
    wr(`ASP_OFS_DIR, 32'h0F, `ASP_RESP_OKAY);
    wr(`ASP_OFS_LATCH, 32'hA5, `ASP_RESP_OKAY);
    pin_in <= 8'h3C;
    upd();
    chk("oe", 8'hF0, pin_oe);
    chk("out", 8'hA0, pin_out);
    chk("dig", 8'hFF, dig_in_en);
    chk("ana", 8'h00, ana_conn);
    rchk(`ASP_OFS_PINS, 32'h3C, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, 32'h5, `ASP_RESP_OKAY);
    upd();
    chk("prohib", 1'b1, prohibited);
    chk("oe", 8'hD0, pin_oe);
    rchk(`ASP_OFS_STATUS, 32'h20, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, 32'hF, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CONFIG, 32'hFF, `ASP_RESP_OKAY);
    upd();
    chk("prohib", 1'b1, prohibited);
    chk("oe", 8'h00, pin_oe);
    chk("ana", 8'h0F, ana_conn);
    wr(`ASP_OFS_DIR, 32'hFF, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, 32'h5, `ASP_RESP_OKAY);
    upd();
    chk("prohib", 1'b0, prohibited);
    chk("conv", 8'h20, conv_pin_sel);
    $display("test digital done");
  endtask : t_digital

  task automatic t_opamp();
    wr(`ASP_OFS_AMPCTL, 32'h80, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_AMPCTL, 32'h80, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, 32'h1, `ASP_RESP_OKAY);
    upd();
    chk("opa", 1'b1, opamp_zero_enable);
    chk("opin", 2'b11, opa_in_conn);
    chk("opout", 1'b1, opamp_zero_output_pin);
    chk("gain_amp_input_pin", 1'b0, gain_amp_input_pin);
    chk("conv", 8'h02, conv_pin_sel);
    wr(`ASP_OFS_CHSEL, 32'h2, `ASP_RESP_OKAY);
    upd();
    chk("prohib", 1'b1, prohibited);
    chk("conv", 8'h00, conv_pin_sel);
    chk("opin", 2'b01, opa_in_conn);
    wr(`ASP_OFS_CHSEL, 32'hF, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CONFIG, 32'hFD, `ASP_RESP_OKAY);
    upd();
    chk("prohib", 1'b1, prohibited);
    wr(`ASP_OFS_CONFIG, 32'hFF, `ASP_RESP_OKAY);
    $display("test opamp done");
  endtask : t_opamp

  task automatic t_gain();
    wr(`ASP_OFS_AMPCTL, 32'h40, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_AMPCTL, 32'h40, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, `ASP_CH_PGA, `ASP_RESP_OKAY);
    upd();
    chk("gain_amp_input_pin", 1'b1, gain_amp_input_pin);
    chk("opout", 1'b0, opamp_zero_output_pin);
    chk("cpga", 1'b1, conv_pga_sel);
    chk("pga", 1'b1, gain_amp_enable);
    rchk(`ASP_OFS_STATUS, 32'h100, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, 32'h1, `ASP_RESP_OKAY);
    upd();
    chk("cpga", 1'b0, conv_pga_sel);
    chk("conv", 8'h02, conv_pin_sel);
    wr(`ASP_OFS_AMPCTL, 32'hC0, `ASP_RESP_OKAY);
    wr(`ASP_OFS_CHSEL, `ASP_CH_PGA, `ASP_RESP_OKAY);
    upd();
    chk("opout", 1'b1, opamp_zero_output_pin);
    chk("gain_amp_input_pin", 1'b1, gain_amp_input_pin);
    chk("cpga", 1'b1, conv_pga_sel);
    rchk(`ASP_OFS_ROLES, 32'h004924F3, `ASP_RESP_OKAY);
    wr(`ASP_OFS_AMPCTL, 32'hFF, `ASP_RESP_OKAY);
    rchk(`ASP_OFS_AMPCTL, 32'hC0, `ASP_RESP_OKAY);
    $display("test gain done");
  endtask : t_gain

  task automatic t_bus();
    wr(8'h20, 32'h1, `ASP_RESP_SLVERR);
    rchk(8'h20, 32'h0, `ASP_RESP_SLVERR);
    b_late = 1;
    wr(`ASP_OFS_PINS, 32'h1, `ASP_RESP_SLVERR);
    b_late = 0;
    s_wstrb <= 4'hE;
    wr(`ASP_OFS_LATCH, 32'hFF, `ASP_RESP_OKAY);
    s_wstrb <= 4'hF;
    rchk(`ASP_OFS_LATCH, 32'hA5, `ASP_RESP_OKAY);
    $display("test bus done");
  endtask : t_bus

  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_digital();
    t_opamp();
    t_gain();
    t_bus();
    wrap_up();
  end
endmodule : tb_asp_port
